//--- rtl/bsmp_bit_sync.v
// Two flip-flop synchroniser for one level from outside the clock domain.
// Assumes clock is the block clock and srst is synchronous, active high.
`timescale 1ns/1ps
`default_nettype none
`include "bsmp_regs.vh"

module bsmp_bit_sync (
  input wire clock,
  input wire srst,
  input wire asyncIn,
  output wire syncOut
);
  reg meta_ff;
  reg sync_ff;

  // First stage only feeds the second
  always @(posedge clock) begin
    if (srst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= asyncIn;
      sync_ff <= meta_ff;
    end
  end

  assign syncOut = sync_ff;
endmodule // bsmp_bit_sync

`default_nettype wire

//--- rtl/bsmp_byte_serial_master_port.v
// Byte serial master port: one full-duplex byte per start command.
// Assumes a core on the same clock drives start, txByte and clockInvert;
// the receive pin comes from outside and is synchronised here.
// What this block does
// - Each start command shifts exactly one transmit byte out on the transmit pin.
// - A receive byte is shifted in from the receive pin during the same transfer.
// - The port always drives the shift clock; the peripheral takes it as input.
// - Completion of every byte is signalled, optionally as a request held until the flag is cleared.
// - Each byte needs a new start, so an idle gap separates transfers.
// - With clock invert one, transmit shifts on falling, receive samples on rising.
// - With clock invert zero, transmit shifts on rising, receive samples on falling.
`timescale 1ns/1ps
`default_nettype none
`include "bsmp_regs.vh"

module bsmp_byte_serial_master_port #(
  parameter [7:0] HALF_DIV = `BSMP_HALF_DIV
) (
  input wire clock,
  input wire srst,
  input wire start,
  input wire [7:0] txByte,
  input wire clockInvert,
  input wire doneIrqEnable,
  input wire doneClear,
  input wire portReceiveDataPin,
  output wire portTransmitDataPin,
  output wire portShiftClock,
  output wire busy,
  output wire [7:0] rxByte,
  output wire doneFlag,
  output wire doneIrq
);
  reg [1:0] state_ff, nxt_state;
  reg [7:0] div_ff, nxt_div;
  reg [2:0] bit_ff, nxt_bit;
  reg [7:0] txSh_ff, nxt_txSh;
  reg [7:0] rxSh_ff, nxt_rxSh;
  reg [7:0] rxByte_ff, nxt_rxByte;
  reg sck_ff, nxt_sck;
  reg txd_ff, nxt_txd;
  reg done_ff, nxt_done;
  wire rxdSync;
  wire divEnd;
  wire lastBit;
  wire idleLevel;

  // State codes of the transfer engine
  localparam [1:0] ST_IDLE = `BSMP_ST_IDLE;
  localparam [1:0] ST_LEAD = `BSMP_ST_LEAD;
  localparam [1:0] ST_TRAIL = `BSMP_ST_TRAIL;
  localparam [1:0] ST_DONE = `BSMP_ST_DONE;

  // Receive pin crosses into the clock domain
  bsmp_bit_sync uRxdSync (
    .clock(clock),
    .srst(srst),
    .asyncIn(portReceiveDataPin),
    .syncOut(rxdSync)
  );

  // End of a half period of the shift clock
  assign divEnd = (div_ff == (HALF_DIV - 8'h01));
  // Last of the eight bits is on the link
  assign lastBit = (bit_ff == `BSMP_LAST_BIT);
  // Clock rests away from the edge that shifts
  assign idleLevel = ~clockInvert;

  // Sequencing: states, half period counter, bit counter
  always @* begin
    nxt_state = state_ff;
    nxt_div = div_ff;
    nxt_bit = bit_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_div = `BSMP_RST_CNT;
        if (start) begin
          nxt_bit = `BSMP_RST_BIT;
          nxt_state = ST_LEAD;
        end
      end
      ST_LEAD: begin
        if (divEnd) begin
          nxt_div = `BSMP_RST_CNT;
          nxt_state = ST_TRAIL;
        end else begin
          nxt_div = div_ff + 8'h01;
        end
      end
      ST_TRAIL: begin
        if (divEnd) begin
          nxt_div = `BSMP_RST_CNT;
          if (lastBit) begin
            nxt_state = ST_DONE;
          end else begin
            nxt_bit = bit_ff + 3'h1;
            nxt_state = ST_LEAD;
          end
        end else begin
          nxt_div = div_ff + 8'h01;
        end
      end
      ST_DONE: begin
        // Back to idle; next byte waits for a new start
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Shift clock and transmit pin
  always @* begin
    nxt_sck = sck_ff;
    nxt_txd = txd_ff;
    nxt_txSh = txSh_ff;
    case (state_ff)
      ST_IDLE: begin
        // Port drives the clock, resting at idle
        nxt_sck = idleLevel;
        // First bit leaves with the start, MSB first
        if (start) begin
          nxt_txd = txByte[7];
          nxt_txSh = {txByte[6:0], 1'b0};
        end
      end
      ST_LEAD: begin
        if (divEnd) begin
          nxt_sck = ~sck_ff;
        end
      end
      ST_TRAIL: begin
        if (divEnd) begin
          nxt_sck = ~sck_ff;
          if (!lastBit) begin
            nxt_txd = txSh_ff[7];
            nxt_txSh = {txSh_ff[6:0], 1'b0};
          end
        end
      end
      default: begin
        nxt_sck = sck_ff;
      end
    endcase
  end

  // Receive shifter, receive buffer and completion flag
  always @* begin
    nxt_rxSh = rxSh_ff;
    nxt_rxByte = rxByte_ff;
    nxt_done = done_ff;
    // Clear by the core; a completing byte overrides it
    if (doneClear) begin
      nxt_done = 1'b0;
    end
    case (state_ff)
      ST_LEAD: begin
        if (divEnd) begin
          nxt_rxSh = {rxSh_ff[6:0], rxdSync};
        end
      end
      ST_DONE: begin
        nxt_rxByte = rxSh_ff;
        nxt_done = 1'b1;
      end
      default: begin
        nxt_rxSh = rxSh_ff;
      end
    endcase
  end

  // Sequencing registers
  always @(posedge clock) begin
    if (srst) begin
      state_ff <= ST_IDLE;
      div_ff <= `BSMP_RST_CNT;
      bit_ff <= `BSMP_RST_BIT;
    end else begin
      state_ff <= nxt_state;
      div_ff <= nxt_div;
      bit_ff <= nxt_bit;
    end
  end

  // Link side registers; transmit pin idles high after reset
  always @(posedge clock) begin
    if (srst) begin
      sck_ff <= `BSMP_RST_SCK;
      txd_ff <= `BSMP_RST_TXD;
      txSh_ff <= `BSMP_RST_BYTE;
      rxSh_ff <= `BSMP_RST_BYTE;
    end else begin
      sck_ff <= nxt_sck;
      txd_ff <= nxt_txd;
      txSh_ff <= nxt_txSh;
      rxSh_ff <= nxt_rxSh;
    end
  end

  // Core side registers: receive buffer and sticky flag
  always @(posedge clock) begin
    if (srst) begin
      rxByte_ff <= `BSMP_RST_BYTE;
      done_ff <= 1'b0;
    end else begin
      rxByte_ff <= nxt_rxByte;
      done_ff <= nxt_done;
    end
  end

  // Outputs
  assign portTransmitDataPin = txd_ff;
  assign portShiftClock = sck_ff;
  assign busy = (state_ff != ST_IDLE);
  assign rxByte = rxByte_ff;
  assign doneFlag = done_ff;
  assign doneIrq = done_ff & doneIrqEnable;
endmodule // bsmp_byte_serial_master_port

`default_nettype wire

//--- rtl/bsmp_regs.vh
// Constants for the byte serial master port: bit counts, states, clock divider.
// Assumes inclusion by bsmp_byte_serial_master_port.v and bsmp_bit_sync.v.
`ifndef BSMP_REGS_VH
`define BSMP_REGS_VH

// Bits per transfer
`define BSMP_BITS 4'h8
// Last bit index
`define BSMP_LAST_BIT 3'h7
// Default half period of the shift clock in system clocks
`define BSMP_HALF_DIV 8'h04
// State codes
`define BSMP_ST_IDLE 2'h0
`define BSMP_ST_LEAD 2'h1
`define BSMP_ST_TRAIL 2'h2
`define BSMP_ST_DONE 2'h3
// Reset values
`define BSMP_RST_BYTE 8'h00
`define BSMP_RST_CNT 8'h00
`define BSMP_RST_BIT 3'h0
`define BSMP_RST_SCK 1'h0
`define BSMP_RST_TXD 1'h1

`endif

//--- verification/bsmp_byte_serial_master_port_tb_top.sv
// Bench: byte transfers against the peer model.
// Assumes design, checker and model compile first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error %0t %h %h", $time, a, b); end end
module bsmp_byte_serial_master_port_tb_top;
  logic clock = 0, srst = 1, start = 0, clockInvert = 0, doneIrqEnable = 0;
  logic doneClear = 0, ld = 0, portTransmitDataPin, portShiftClock, busy, doneFlag, doneIrq;
  logic [7:0] txByte = 8'h00, load = 8'h00, rxByte, got, sh;
  logic portReceiveDataPin;
  int error_cnt = 0, cmp_count = 0;
  assign portReceiveDataPin = sh[7];
  always #5 clock = ~clock;
  bsmp_byte_serial_master_port #(.HALF_DIV(8'h04)) bsmp_byte_serial_master_port_i (.*);
  bsmp_peer_model bsmp_peer_model_i (.sck(portShiftClock), .clkInv(clockInvert),
    .txd(portTransmitDataPin), .ld(ld), .load(load), .got(got), .sh(sh));
  // One byte; hold keeps start up to be refused
  task automatic xfer(input logic [7:0] t, r, input bit hold);
    int n;
    @(posedge clock);
    start <= 1;
    txByte <= t;
    load <= r;
    ld <= 1;
    @(posedge clock);
    start <= hold;
    ld <= 0;
    txByte <= ~t;
    @(negedge clock);
    for (n = 0; n < 200 && busy !== 1'b0; n++) begin
      @(posedge clock);
      if (n == 60) start <= 0;
      @(negedge clock);
    end
    `CHK(n, 65)
    `CHK(got, t)
    `CHK(rxByte, r)
    `CHK(doneFlag, 1'b1)
    `CHK(doneIrq, doneIrqEnable)
    @(posedge clock);
    doneClear <= 1;
    @(posedge clock);
    doneClear <= 0;
    @(negedge clock);
    `CHK(doneFlag, 1'b0)
  endtask
  task t_plain;
    xfer(8'ha5, 8'h3c, 0);
  endtask
  task t_invert;
    @(posedge clock);
    clockInvert <= 1;
    doneIrqEnable <= 1;
    xfer(8'h81, 8'h7e, 0);
  endtask
  task t_refuse;
    xfer(8'h5a, 8'hc3, 1);
    `CHK(busy, 1'b0)
  endtask
  task wrap_up;
    if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Reset, then scenarios
  initial begin
    repeat (4) @(posedge clock);
    srst <= 0;
    @(negedge clock);
    `CHK({portTransmitDataPin, portShiftClock, busy, rxByte, doneFlag}, 12'h800)
    t_plain;
    t_invert;
    t_refuse;
    wrap_up;
  end
  // Watchdog
  initial begin
    #20000;
    error_cnt++;
    wrap_up;
  end
endmodule // bsmp_byte_serial_master_port_tb_top
bind bsmp_byte_serial_master_port bsmp_port_asserts bsmp_port_asserts_i (.*);
`default_nettype wire

//--- verification/bsmp_peer_model.sv
// Peer that takes the shift clock and returns a byte.
// Assumes sck and txd come from the port.
`timescale 1ns/1ps
`default_nettype none
module bsmp_peer_model (
  input wire logic sck,
  input wire logic clkInv,
  input wire logic txd,
  input wire logic ld,
  input wire logic [7:0] load,
  output var logic [7:0] got,
  output var logic [7:0] sh
);
  always @(sck or posedge ld) begin
    if (ld) sh <= load;
    else if (sck === clkInv) got <= {got[6:0], txd};
    else sh <= {sh[6:0], ~sh[0]};
  end
endmodule // bsmp_peer_model
`default_nettype wire

//--- verification/bsmp_port_asserts.sv
// Checker on the serial master port pins.
// Assumes the default divider of four.
`timescale 1ns/1ps
`default_nettype none
module bsmp_port_asserts (
  input wire logic clock,
  input wire logic srst,
  input wire logic start,
  input wire logic clockInvert,
  input wire logic doneIrqEnable,
  input wire logic portTransmitDataPin,
  input wire logic portShiftClock,
  input wire logic busy,
  input wire logic doneFlag,
  input wire logic doneIrq
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  a_start_busy: assert property (start && !busy |=> busy) else $error("no busy");
  a_no_start: assert property (!busy && !start |=> !busy) else $error("busy");
  a_byte_len: assert property ($rose(busy) |-> ##65 $fell(busy)) else $error("len");
  a_done_set: assert property ($fell(busy) |-> doneFlag) else $error("done");
  a_irq_gate: assert property (doneIrq == (doneFlag && doneIrqEnable)) else $error("irq");
  a_idle_sck: assert property (!busy && !$past(busy) && !$past(srst) &&
    $stable(clockInvert) |-> portShiftClock == !clockInvert) else $error("idle");
  a_tx_rise: assert property (busy && !$rose(busy) && !clockInvert &&
    $changed(portTransmitDataPin) |-> $rose(portShiftClock)) else $error("tx0");
  a_tx_fall: assert property (busy && !$rose(busy) && clockInvert &&
    $changed(portTransmitDataPin) |-> $fell(portShiftClock)) else $error("tx1");
  cover property ($fell(busy) && clockInvert);
  cover property ($fell(busy) && !clockInvert);
  cover property (doneIrq);
endmodule // bsmp_port_asserts
`default_nettype wire
